// file: src/fie_core.sv
// Fixed instruction executor core with its register bus slave
// Operation
// RQ1: Copy rotated source, source itself left intact
// RQ2: Add rotated source to implicit operand
// RQ3: AND rotated source with implicit operand
// RQ4: AND with low-nibble mask clears upper nibble
// RQ5: XOR rotated source with implicit operand
// RQ6: No inclusive-OR operation exists
// RQ7: Literal load into register or variable
// RQ8: Storage select literal picks storage byte
// RQ9: I/O select literal picks I/O byte
// RQ10: Field writes alter only destination field bits
// RQ11: Indexed execute runs entry base plus index
// RQ12: Resume after indexed execute unless jump taken
// RQ13: Branch if operand nonzero, else fall through
// RQ14: Jump loads program counter with target
// RQ15: Program selects storage page before byte; the core has one 256-byte storage with no page select
// RQ16: Variables are byte, rightmost bit, length
// RQ17: I/O bank left, storage bank right
// RQ18: Add carry kept in readable overflow register
// RQ19: Every operation completes in one cycle
`timescale 1ns/1ps
`default_nettype none
module fie_core
   import fie_pkg::*;
(
   input  wire logic        clk,      // 250 MHz clock
   input  wire logic        rstn,     // Async reset, active low
   input  wire logic        wb_cyc_i, // Bus cycle
   input  wire logic        wb_stb_i, // Bus strobe
   input  wire logic        wb_we_i,  // Bus write
   input  wire logic [7:0]  wb_adr_i, // Byte address
   input  wire logic [3:0]  wb_sel_i, // Byte enables
   input  wire logic [31:0] wb_dat_i, // Write data
   output var  logic [31:0] wb_dat_o, // Read data
   output var  logic        wb_ack_o, // Bus acknowledge
   input  wire logic [7:0]  io_in,    // Selected I/O byte from pins
   output var  logic [7:0]  io_out,   // I/O output latch
   output var  logic        io_wr,    // I/O write pulse
   output var  logic [7:0]  io_sel    // io_byte_select to the ports
);

   typedef struct packed {
      fie_state_t      st;
      logic [7:0]      pc;
      logic [7:0]      ret;
      logic            in_xec;
      logic [7:0][7:0] regs;
      logic            ovf;
      logic [7:0]      ws_sel;
      logic [7:0]      io_sel;
      logic [7:0]      io_out;
      logic            io_wr;
      logic [7:0]      paddr;
      logic            ack;
      logic [31:0]     dat;
      logic [7:0]      sync1;
      logic [7:0]      sync2;
   } fie_core_t;

   fie_core_t   r_reg;
   fie_core_t   r_next;
   logic [31:0] pmem [256];
   logic [7:0]  wsmem [256];

   logic [31:0] instr;
   fie_op_t     op;
   logic [4:0]  src;
   logic [4:0]  dst;
   logic [2:0]  rot;
   logic [2:0]  pos;
   logic [2:0]  len;
   logic [7:0]  lit;
   logic [7:0]  src_byte;
   logic [7:0]  dst_old;
   logic [7:0]  alu_res;
   logic        alu_carry;
   logic [7:0]  dmask;
   logic [7:0]  merged;
   logic        exec;
   logic        bus_req;
   logic        bus_wr;
   logic        ws_we;
   logic        pm_we;
   logic [31:0] pm_wdata;
   logic [31:0] status;
   logic [31:0] selword;
   logic [15:0] ref_dbl;
   logic [7:0]  ref_rot;

   // Instruction fields
   always_comb
   begin
      instr = pmem[r_reg.pc];
      op    = fie_op_t'(instr[OP_HI:OP_LO]);
      src   = instr[SRC_HI:SRC_LO];
      rot   = instr[ROT_HI:ROT_LO];
      dst   = instr[DST_HI:DST_LO];
      pos   = instr[POS_HI:POS_LO]; // RQ16
      len   = instr[LEN_HI:LEN_LO]; // RQ16
      lit   = instr[LIT_HI:LIT_LO];
   end

   assign exec    = (r_reg.st != ST_HALT);
   assign bus_req = wb_cyc_i && wb_stb_i && !r_reg.ack;
   assign bus_wr  = bus_req && wb_we_i;

   // Source selection; I/O bank reads the synchronised pins
   always_comb
   begin
      if (src[4:3] == BANK_WS)
         src_byte = wsmem[r_reg.ws_sel]; // RQ17
      else if (src[4:3] == BANK_IO)
         src_byte = r_reg.sync2; // RQ17
      else if (src == CODE_OVF)
         src_byte = {7'h00, r_reg.ovf}; // RQ18
      else if (src < CODE_REGS)
         src_byte = r_reg.regs[src[2:0]];
      else
         src_byte = BYTE_Z;
   end

   // Old destination byte for field merges; I/O merges into the latch
   always_comb
   begin
      if (dst[4:3] == BANK_WS)
         dst_old = wsmem[r_reg.ws_sel];
      else
         dst_old = r_reg.io_out;
   end

   fie_alu u_alu (
      .op      (op),
      .src     (src_byte),
      .rot     (rot),
      .len     (len),
      .is_bank (src[4]),
      .aux     (r_reg.regs[0]),
      .lit     (lit),
      .res     (alu_res),
      .carry   (alu_carry)
   );

   fie_merge u_merge (
      .old_byte (dst_old),
      .val      (alu_res),
      .pos      (pos),
      .len      (len),
      .mask     (dmask),
      .merged   (merged)
   );

   // Program word write honours byte enables
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++)
      begin : g_pm_byte
         assign pm_wdata[gb*8 +: 8] = wb_sel_i[gb] ? wb_dat_i[gb*8 +: 8]
                                                   : pmem[r_reg.paddr][gb*8 +: 8];
      end
   endgenerate

   // Read views of the executor state
   always_comb
   begin
      status                        = WORD_Z;
      status[STAT_PC_HI:STAT_PC_LO] = r_reg.pc;
      status[STAT_OVF]              = r_reg.ovf;
      status[STAT_XEC]              = r_reg.in_xec;
      status[STAT_ST_HI:STAT_ST_LO] = r_reg.st;
      selword                       = WORD_Z;
      selword[SEL_IO_HI:SEL_IO_LO]  = r_reg.io_sel;
      selword[SEL_WS_HI:SEL_WS_LO]  = r_reg.ws_sel;
      selword[SEL_OVF]              = r_reg.ovf; // RQ18
   end

   // Next state: one whole instruction per clock, bus access after it
   always_comb
   begin
      r_next       = r_reg;
      r_next.ack   = 1'b0;
      r_next.io_wr = 1'b0;
      r_next.sync1 = io_in;
      r_next.sync2 = r_reg.sync1;
      ws_we        = 1'b0;
      pm_we        = 1'b0;
      if (exec) // RQ19
      begin
         // Entry of an indexed execute returns past the caller
         if (r_reg.in_xec)
            r_next.pc = r_reg.ret; // RQ12
         else
            r_next.pc = r_reg.pc + 8'h01;
         r_next.in_xec = 1'b0;
         case (op)
            OP_COPY, OP_ADD, OP_AND, OP_XOR, OP_LIT:
            begin
               if (op == OP_ADD)
                  r_next.ovf = alu_carry; // RQ18
               if (dst[4:3] == BANK_WS)
                  ws_we = 1'b1; // RQ10
               else if (dst[4:3] == BANK_IO)
               begin
                  r_next.io_out = merged; // RQ10
                  r_next.io_wr  = 1'b1;
               end
               else if (dst == CODE_IOSEL)
                  r_next.io_sel = alu_res; // RQ9
               else if (dst == CODE_WSSEL)
                  r_next.ws_sel = alu_res; // RQ8
               else if (dst < CODE_REGS)
                  r_next.regs[dst[2:0]] = alu_res; // RQ1 RQ2 RQ3 RQ5 RQ7
            end
            OP_XEC:
            begin
               // Nested indexed execute keeps the first return point
               r_next.pc     = lit + alu_res; // RQ11
               r_next.in_xec = 1'b1;
               r_next.ret    = r_reg.in_xec ? r_reg.ret : r_reg.pc + 8'h01;
            end
            OP_NZT:
            begin
               if (alu_res != BYTE_Z)
                  r_next.pc = lit; // RQ13
            end
            OP_JMP:
               r_next.pc = lit; // RQ14
            default:
               r_next.pc = r_next.pc;
         endcase
         if (r_reg.st == ST_STEP)
            r_next.st = ST_HALT;
      end
      // Bus slave: every access, mapped or not, acks next cycle
      if (bus_req)
      begin
         r_next.ack = 1'b1;
         r_next.dat = WORD_Z;
         if (wb_we_i)
         begin
            case (wb_adr_i)
               ADR_CTRL:
               begin
                  if (wb_sel_i[0])
                  begin
                     if (wb_dat_i[CTRL_RUN])
                        r_next.st = ST_RUN;
                     else if (wb_dat_i[CTRL_STEP])
                        r_next.st = ST_STEP;
                     else
                        r_next.st = ST_HALT;
                     if (wb_dat_i[CTRL_RESTART])
                     begin
                        r_next.pc     = PC_RST;
                        r_next.in_xec = 1'b0;
                     end
                  end
               end
               ADR_PADDR:
               begin
                  if (wb_sel_i[0])
                     r_next.paddr = wb_dat_i[7:0];
               end
               ADR_PDATA:
               begin
                  pm_we        = 1'b1;
                  r_next.paddr = r_reg.paddr + 8'h01;
               end
               default:
                  r_next.dat = WORD_Z;
            endcase
         end
         else
         begin
            case (wb_adr_i)
               ADR_CTRL:   r_next.dat = {29'h0000_0000, 1'b0, r_reg.st == ST_STEP,
                                         r_reg.st == ST_RUN};
               ADR_STATUS: r_next.dat = status;
               ADR_PADDR:  r_next.dat = {24'h00_0000, r_reg.paddr};
               ADR_PDATA:  r_next.dat = pmem[r_reg.paddr];
               ADR_REGLO:  r_next.dat = r_reg.regs[3:0];
               ADR_REGHI:  r_next.dat = r_reg.regs[7:4];
               ADR_SEL:    r_next.dat = selword;
               default:    r_next.dat = WORD_Z;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         r_reg    <= '0;
         r_reg.st <= ST_HALT;
         r_reg.pc <= PC_RST;
      end
      else
         r_reg <= r_next;
   end

   // Memories carry no reset; software loads the program before running
   always_ff @(posedge clk)
   begin
      if (pm_we)
         pmem[r_reg.paddr] <= pm_wdata;
      if (ws_we)
         wsmem[r_reg.ws_sel] <= merged; // RQ10
   end

   assign wb_dat_o = r_reg.dat;
   assign wb_ack_o = r_reg.ack;
   assign io_out   = r_reg.io_out;
   assign io_wr    = r_reg.io_wr;
   assign io_sel   = r_reg.io_sel;

   // Reference rotation for the checks below
   assign ref_dbl = {src_byte, src_byte} >> rot;
   assign ref_rot = ref_dbl[7:0];

   property p_jump;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_JMP && !bus_wr) |=> (r_reg.pc == $past(lit));
   endproperty
   a_jump: assert property (p_jump) else $error("jump target not loaded"); // RQ14

   property p_nzt_taken;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_NZT && !src[4] && ref_rot != BYTE_Z && !bus_wr)
         |=> (r_reg.pc == $past(lit));
   endproperty
   a_nzt_taken: assert property (p_nzt_taken) else $error("branch not taken"); // RQ13

   property p_nzt_fall;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_NZT && src_byte == BYTE_Z && !r_reg.in_xec && !bus_wr)
         |=> (r_reg.pc == $past(r_reg.pc) + 8'h01);
   endproperty
   a_nzt_fall: assert property (p_nzt_fall) else $error("zero did not fall through"); // RQ13

   property p_copy;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_COPY && dst < CODE_REGS && src < CODE_REGS && src != dst)
         |=> (r_reg.regs[$past(dst[2:0])] == $past(ref_rot))
             && (r_reg.regs[$past(src[2:0])] == $past(src_byte));
   endproperty
   a_copy: assert property (p_copy) else $error("copy result wrong"); // RQ1

   property p_add;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_ADD && dst < CODE_REGS && src < CODE_REGS)
         |=> ({r_reg.ovf, r_reg.regs[$past(dst[2:0])]}
              == 9'($past(ref_rot)) + 9'($past(r_reg.regs[0])));
   endproperty
   a_add: assert property (p_add) else $error("sum or carry wrong"); // RQ2 RQ18

   property p_and_mask;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_AND && dst < CODE_REGS && src < CODE_REGS && dst != CODE_AUX
       && r_reg.regs[0] == 8'h0F)
         |=> (r_reg.regs[$past(dst[2:0])] == {4'h0, $past(ref_rot[3:0])});
   endproperty
   a_and_mask: assert property (p_and_mask) else $error("nibble mask failed"); // RQ4 RQ3

   property p_xor;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_XOR && dst < CODE_REGS && src < CODE_REGS)
         |=> (r_reg.regs[$past(dst[2:0])] == ($past(ref_rot) ^ $past(r_reg.regs[0])));
   endproperty
   a_xor: assert property (p_xor) else $error("xor result wrong"); // RQ5

   property p_xec;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_XEC && !src[4] && !bus_wr)
         |=> (r_reg.in_xec && r_reg.pc == $past(lit) + $past(ref_rot));
   endproperty
   a_xec: assert property (p_xec) else $error("indexed entry wrong"); // RQ11

   property p_xec_ret;
      @(posedge clk) disable iff (!rstn)
      (exec && r_reg.in_xec && op inside {OP_COPY, OP_ADD, OP_AND, OP_XOR, OP_LIT}
       && !bus_wr)
         |=> (!r_reg.in_xec && r_reg.pc == $past(r_reg.ret));
   endproperty
   a_xec_ret: assert property (p_xec_ret) else $error("no return after entry"); // RQ12

   property p_io_select;
      @(posedge clk) disable iff (!rstn)
      (exec && op == OP_LIT && dst == CODE_IOSEL) |=> (io_sel == $past(lit));
   endproperty
   a_io_select: assert property (p_io_select) else $error("io select not loaded"); // RQ9

   property p_io_field;
      @(posedge clk) disable iff (!rstn)
      (exec && dst[4:3] == BANK_IO && op inside {OP_COPY, OP_ADD, OP_AND, OP_XOR, OP_LIT})
         |=> io_wr && (((io_out ^ $past(r_reg.io_out)) & ~$past(dmask)) == BYTE_Z);
   endproperty
   a_io_field: assert property (p_io_field) else $error("bits outside field changed"); // RQ10

endmodule
`default_nettype wire

// file: include/fie_pkg.sv
// Shared constants and types of the fixed instruction executor
package fie_pkg;

   // Register offsets on the bus (byte addresses, one word each)
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_PADDR  = 8'h08;
   localparam logic [7:0] ADR_PDATA  = 8'h0C;
   localparam logic [7:0] ADR_REGLO  = 8'h10;
   localparam logic [7:0] ADR_REGHI  = 8'h14;
   localparam logic [7:0] ADR_SEL    = 8'h18;

   // Control register bits
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_STEP    = 1;
   localparam int CTRL_RESTART = 2;

   // Status register fields
   localparam int STAT_PC_LO = 0;
   localparam int STAT_PC_HI = 7;
   localparam int STAT_OVF   = 8;
   localparam int STAT_XEC   = 9;
   localparam int STAT_ST_LO = 10;
   localparam int STAT_ST_HI = 12;

   // Selector register fields
   localparam int SEL_IO_LO = 0;
   localparam int SEL_IO_HI = 7;
   localparam int SEL_WS_LO = 8;
   localparam int SEL_WS_HI = 15;
   localparam int SEL_OVF   = 16;

   // Instruction word fields
   localparam int OP_HI  = 31;
   localparam int OP_LO  = 29;
   localparam int SRC_HI = 28;
   localparam int SRC_LO = 24;
   localparam int ROT_HI = 23;
   localparam int ROT_LO = 21;
   localparam int DST_HI = 20;
   localparam int DST_LO = 16;
   localparam int POS_HI = 15;
   localparam int POS_LO = 13;
   localparam int LEN_HI = 12;
   localparam int LEN_LO = 10;
   localparam int LIT_HI = 7;
   localparam int LIT_LO = 0;

   // Operand codes: 0..7 registers (0 is the implicit operand), banks by top bits
   localparam logic [4:0] CODE_AUX   = 5'h00;
   localparam logic [4:0] CODE_OVF   = 5'h08;
   localparam logic [4:0] CODE_IOSEL = 5'h08;
   localparam logic [4:0] CODE_WSSEL = 5'h09;
   localparam logic [4:0] CODE_REGS  = 5'h08;
   localparam logic [1:0] BANK_WS    = 2'h2;
   localparam logic [1:0] BANK_IO    = 2'h3;

   // Reset values, zero constants and field mask constants
   localparam logic [7:0]  PC_RST  = 8'h00;
   localparam logic [7:0]  BYTE_Z  = 8'h00;
   localparam logic [31:0] WORD_Z  = 32'h0000_0000;
   localparam logic [7:0]  FULL_B  = 8'hFF;
   localparam logic [2:0]  TOP_BIT = 3'h7;

   // Opcodes; there is deliberately no inclusive-OR
   typedef enum logic [2:0] {
      OP_COPY = 3'h0,
      OP_ADD  = 3'h1,
      OP_AND  = 3'h2,
      OP_XOR  = 3'h3,
      OP_XEC  = 3'h4,
      OP_NZT  = 3'h5,
      OP_LIT  = 3'h6,
      OP_JMP  = 3'h7
   } fie_op_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_HALT = 3'b001,
      ST_RUN  = 3'b010,
      ST_STEP = 3'b100
   } fie_state_t;

endpackage

// file: src/fie_alu.sv
// Source rotation, field masking and the arithmetic or logic step
`timescale 1ns/1ps
`default_nettype none
module fie_alu
   import fie_pkg::*;
(
   input  wire fie_op_t    op,       // Current opcode
   input  wire logic [7:0] src,      // Raw source byte
   input  wire logic [2:0] rot,      // Right rotate amount
   input  wire logic [2:0] len,      // Field length minus one
   input  wire logic       is_bank,  // Source is a bank byte field
   input  wire logic [7:0] aux,      // Implicit operand
   input  wire logic [7:0] lit,      // Literal of the instruction
   output var  logic [7:0] res,      // Result byte
   output var  logic       carry     // Carry out of an add
);

   logic [15:0] dbl;
   logic [7:0]  rotated;
   logic [7:0]  mask;
   logic [7:0]  operand;

   // Rotate, then cut a bank field down to its length
   always_comb
   begin
      dbl     = {src, src} >> rot;
      rotated = dbl[7:0];
      mask    = FULL_B >> (TOP_BIT - len);
      operand = is_bank ? (rotated & mask) : rotated;
      carry   = 1'b0;
      // Eight opcodes fill the field, so an inclusive OR has no code
      case (op) // RQ6
         OP_ADD:  {carry, res} = 9'(operand) + 9'(aux); // RQ2
         OP_AND:  res = operand & aux; // RQ3 RQ4
         OP_XOR:  res = operand ^ aux; // RQ5
         OP_LIT:  res = lit; // RQ7
         default: res = operand; // RQ1
      endcase
   end

endmodule
`default_nettype wire

// file: src/fie_merge.sv
// Inserts a value into a bit field of a byte, other bits kept
`timescale 1ns/1ps
`default_nettype none
module fie_merge
   import fie_pkg::*;
(
   input  wire logic [7:0] old_byte, // Byte before the write
   input  wire logic [7:0] val,      // Right-justified field value
   input  wire logic [2:0] pos,      // Rightmost bit of the field
   input  wire logic [2:0] len,      // Field length minus one
   output var  logic [7:0] mask,     // Bits the write alters
   output var  logic [7:0] merged    // Byte after the write
);

   // Fields running past bit 7 are cut off, not wrapped
   always_comb
   begin
      mask   = (FULL_B >> (TOP_BIT - len)) << pos;
      merged = (old_byte & ~mask) | ((val << pos) & mask);
   end

endmodule
`default_nettype wire

// file: verification/fie_io_model.sv
// I/O port bank model on the far side of the io vector bus
`timescale 1ns/1ps
`default_nettype none
module fie_io_model #(
   parameter logic [7:0] PAT = 8'h5C
) (
   input  wire logic       clk,    // Processor clock
   input  wire logic [7:0] io_sel, // Selected port
   input  wire logic [7:0] io_out, // Output latch of the core
   input  wire logic       io_wr,  // Write pulse
   output var  logic [7:0] io_in   // Contents of selected port
);
   logic [7:0] port_mem [256];

   // Ports preset to a per-port pattern, so a wrong select shows
   initial
   begin
      for (int i = 0; i < 256; i++)
      begin
         port_mem[i] = 8'(i) ^ PAT;
      end
   end

   // Selected port drives the left bank continuously
   assign io_in = port_mem[io_sel];

   // Write lands in the port selected during the pulse
   always @(posedge clk)
   begin
      if (io_wr)
      begin
         port_mem[io_sel] <= io_out;
      end
   end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the fixed instruction executor core
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fie_pkg::*;
;
   logic        clk, rstn, cyc, stb, we, ack, io_wr;
   logic [7:0]  adr, io_in, io_out, io_sel;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, rd;
   logic [31:0] pg [$];
   int          n_fail, tests_run;

   fie_core dut (
      .clk      (clk),
      .rstn     (rstn),
      .wb_cyc_i (cyc),
      .wb_stb_i (stb),
      .wb_we_i  (we),
      .wb_adr_i (adr),
      .wb_sel_i (sel),
      .wb_dat_i (wdat),
      .wb_dat_o (rdat),
      .wb_ack_o (ack),
      .io_in    (io_in),
      .io_out   (io_out),
      .io_wr    (io_wr),
      .io_sel   (io_sel)
   );

   fie_io_model #(.PAT(8'h5C)) ports (
      .clk    (clk),
      .io_sel (io_sel),
      .io_out (io_out),
      .io_wr  (io_wr),
      .io_in  (io_in)
   );

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] ins(input logic [2:0] op, input logic [4:0] s,
      input logic [2:0] r, input logic [4:0] d, input logic [2:0] p, input logic [2:0] l,
      input logic [7:0] k);
      ins = {op, s, r, d, p, l, 2'b00, k};
   endfunction

   // Full-byte literal load
   function automatic logic [31:0] lt(input logic [4:0] d, input logic [7:0] k);
      lt = ins(OP_LIT, 5'h0, 3'h0, d, 3'h0, 3'h7, k);
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic single cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      rd = rdat;
      if (ack !== 1'b1)
         chk("bus ack", 32'h0000_0000, 32'h0000_0001);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, e);
   endtask

   task automatic rst();
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
   endtask

   // Pointer written once, then data words auto-increment it
   task automatic load_at(input logic [7:0] a);
      wb(1'b1, ADR_PADDR, {24'h00_0000, a});
      foreach (pg[i]) wb(1'b1, ADR_PDATA, pg[i]);
   endtask

   // Programs end in a self jump, so a long run is harmless
   task automatic run_prog();
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      repeat (60) @(posedge clk);
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
   endtask

   task automatic t_idle();
      rdchk("status", ADR_STATUS, 32'h0000_0400);
      rdchk("unmapped", 8'h1C, 32'h0000_0000);
   endtask

   task automatic t_alu();
      rst();
      pg = {lt(5'h1, 8'hA5), lt(5'h0, 8'h0F), ins(OP_AND, 5'h1, 3'h0, 5'h2, 3'h0, 3'h7, 8'h0),
         ins(OP_XOR, 5'h1, 3'h4, 5'h3, 3'h0, 3'h7, 8'h0),
         ins(OP_COPY, 5'h1, 3'h1, 5'h4, 3'h0, 3'h7, 8'h0), lt(5'h0, 8'hF0),
         ins(OP_ADD, 5'h1, 3'h0, 5'h5, 3'h0, 3'h7, 8'h0),
         ins(OP_ADD, CODE_OVF, 3'h0, 5'h6, 3'h0, 3'h7, 8'h0),
         ins(OP_JMP, 5'h0, 3'h0, 5'h0, 3'h0, 3'h0, 8'h08)};
      load_at(8'h00);
      run_prog();
      rdchk("regs lo", ADR_REGLO, 32'h5505_A5F0);
      rdchk("regs hi", ADR_REGHI, 32'h00F1_95D2);
      rdchk("selects", ADR_SEL, 32'h0000_0000);
   endtask

   task automatic t_bank();
      rst();
      pg = {lt(CODE_WSSEL, 8'h20), lt(5'h10, 8'hFF),
         ins(OP_LIT, 5'h0, 3'h0, 5'h10, 3'h3, 3'h1, 8'h01),
         lt(CODE_WSSEL, 8'h21), lt(5'h10, 8'h3C), lt(CODE_WSSEL, 8'h20),
         ins(OP_COPY, 5'h10, 3'h3, 5'h2, 3'h0, 3'h1, 8'h0),
         ins(OP_COPY, 5'h10, 3'h0, 5'h1, 3'h0, 3'h7, 8'h0), lt(CODE_WSSEL, 8'h21),
         ins(OP_COPY, 5'h10, 3'h0, 5'h3, 3'h0, 3'h7, 8'h0), lt(CODE_IOSEL, 8'h05),
         lt(5'h18, 8'hA0), lt(5'h5, 8'h00), lt(CODE_IOSEL, 8'h06), lt(5'h5, 8'h00),
         lt(5'h5, 8'h00), lt(5'h5, 8'h00), ins(OP_COPY, 5'h18, 3'h0, 5'h4, 3'h0, 3'h7, 8'h0),
         ins(OP_JMP, 5'h0, 3'h0, 5'h0, 3'h0, 3'h0, 8'h12)};
      load_at(8'h00);
      run_prog();
      rdchk("field regs", ADR_REGLO, 32'h3C01_EF00);
      rdchk("io read", ADR_REGHI, {24'h00_0000, 8'h06 ^ 8'h5C});
      rdchk("selects", ADR_SEL, 32'h0000_2106);
      chk("io_sel", {24'h00_0000, io_sel}, 32'h0000_0006);
      chk("io_out", {24'h00_0000, io_out}, 32'h0000_00A0);
      chk("port 5", {24'h00_0000, ports.port_mem[5]}, 32'h0000_00A0);
   endtask

   task automatic t_flow();
      rst();
      pg = {lt(5'h1, 8'h02), ins(OP_XEC, 5'h1, 3'h0, 5'h0, 3'h0, 3'h0, 8'h0A), lt(5'h2, 8'h77),
         ins(OP_XEC, 5'h6, 3'h0, 5'h0, 3'h0, 3'h0, 8'h0D),
         ins(OP_XEC, 5'h1, 3'h0, 5'h0, 3'h0, 3'h0, 8'h14), lt(5'h3, 8'hEE)};
      load_at(8'h00);
      pg = {lt(5'h4, 8'h01), lt(5'h4, 8'h02), lt(5'h4, 8'h03), lt(5'h7, 8'h99)};
      load_at(8'h0A);
      pg = {ins(OP_JMP, 5'h0, 3'h0, 5'h0, 3'h0, 3'h0, 8'h1E)};
      load_at(8'h16);
      pg = {ins(OP_NZT, 5'h0, 3'h0, 5'h0, 3'h0, 3'h7, 8'h28),
         ins(OP_NZT, 5'h1, 3'h0, 5'h0, 3'h0, 3'h7, 8'h21), lt(5'h5, 8'hBB), lt(5'h5, 8'h11),
         ins(OP_JMP, 5'h0, 3'h0, 5'h0, 3'h0, 3'h0, 8'h22)};
      load_at(8'h1E);
      // One step must move exactly one instruction on
      wb(1'b1, ADR_CTRL, 32'h0000_0002);
      repeat (4) @(posedge clk);
      rdchk("step pc", ADR_STATUS, 32'h0000_0401);
      rdchk("step regs", ADR_REGLO, 32'h0000_0200);
      run_prog();
      rdchk("flow lo", ADR_REGLO, 32'h0077_0200);
      rdchk("flow hi", ADR_REGHI, 32'h9900_1103);
      rdchk("end pc", ADR_STATUS, 32'h0000_0422);
      // Restart clears the counter; read views of control and program
      wb(1'b1, ADR_CTRL, 32'h0000_0004);
      rdchk("restart pc", ADR_STATUS, 32'h0000_0400);
      rdchk("ctrl", ADR_CTRL, 32'h0000_0000);
      wb(1'b1, ADR_PADDR, 32'h0000_001F);
      rdchk("pdata", ADR_PDATA, ins(OP_NZT, 5'h1, 3'h0, 5'h0, 3'h0, 3'h7, 8'h21));
      rdchk("paddr", ADR_PADDR, 32'h0000_001F);
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence; bus idle and reset low from time zero
   initial
   begin
      n_fail = 0;
      tests_run = 0;
      rstn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      wdat = 32'h0000_0000;
      rst();
      t_idle();
      t_alu();
      t_bank();
      t_flow();
      report_and_stop();
   end

   // Watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      #40000;
      n_fail++;
      report_and_stop();
   end
endmodule
`default_nettype wire
